// File: common/zol_pkg.sv
/*
 * Constants for the zero-overhead loop controller: register map, field
 * positions, reset values, retire operation codes and address offsets.
 * Assumes a 32-bit instruction address space with 16-bit aligned code.
 */
package zol_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int COUNT_W = 12;
	localparam int INFO_W = 2;
	localparam int OP_W = 3;
	localparam int DISP_W_DEFAULT = 8;
	localparam int AXI_ADDR_W = 8;

	// Register byte offsets
	localparam logic [AXI_ADDR_W-1:0] OFS_START = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_END = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFS_STATE = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h0c;

	// State word fields
	localparam int STATE_COUNT_LSB = 0;
	localparam int STATE_INFO_LSB = 12;
	localparam int STATE_DSP_BIT = 14;

	// Status word fields
	localparam int STATUS_EXT_BIT = 0;
	localparam int STATUS_ARMED_BIT = 1;
	localparam int STATUS_MATCH_BIT = 2;

	localparam logic [ADDR_W-1:0] START_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] END_RESET = 32'h0000_0000;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
	localparam logic [INFO_W-1:0] INFO_RESET = 2'h0;

	// Program counter seen by PC-relative operations: instruction address + 4
	localparam logic [ADDR_W-1:0] PC_REL_OFFSET = 32'h0000_0004;
	localparam int END_MODE_BIT = 0;
	localparam int IMM_W = 8;

	// Retire operation codes
	localparam logic [OP_W-1:0] OP_NONE = 3'h0;
	localparam logic [OP_W-1:0] OP_SET_START = 3'h1;
	localparam logic [OP_W-1:0] OP_SET_END = 3'h2;
	localparam logic [OP_W-1:0] OP_COUNT_IMM = 3'h3;
	localparam logic [OP_W-1:0] OP_COUNT_REG = 3'h4;
	localparam logic [OP_W-1:0] OP_LEGACY_SETUP = 3'h5;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {ZOL_WR_COLLECT, ZOL_WR_RESP} zol_wr_state_t;
	typedef enum logic {ZOL_RD_IDLE, ZOL_RD_DATA} zol_rd_state_t;

endpackage : zol_pkg

// File: hw/zol_end_match.sv
/*
 * Loop-end comparator: flags when the retiring instruction is the loop end and the count is nonzero.
 * Assumes the address and pointers are stable during the retire cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module zol_end_match
	import zol_pkg::*;
(
	input wire logic [ADDR_W-1:0] inst_addr,
	input wire logic [ADDR_W-1:0] end_ptr,
	input wire logic [COUNT_W-1:0] count,
	output logic hit
);

	logic ext_mode;
	logic addr_eq;

	assign ext_mode = end_ptr[END_MODE_BIT];
	// Extended mode ignores the marker bit in the compare
	assign addr_eq = ext_mode ? (inst_addr[ADDR_W-1:1] == end_ptr[ADDR_W-1:1]) : (inst_addr == end_ptr);
	assign hit = addr_eq && (count != COUNT_RESET);

endmodule : zol_end_match

`default_nettype wire

// File: hw/zol_loop_ctrl.sv
/*
 * Zero-overhead loop controller with an AXI4-Lite register port.
 * Assumes the pipeline presents each retiring instruction for one cycle
 * with its address, decoded loop operation and operand, and that it obeys
 * a redirect presented in the following cycle.
 */
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module zol_loop_ctrl
	import zol_pkg::*;
#(
	parameter int DISP_W = DISP_W_DEFAULT
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic retire_valid,
	input wire logic [ADDR_W-1:0] retire_addr,
	input wire logic [OP_W-1:0] retire_op,
	input wire logic [DISP_W-1:0] retire_disp,
	input wire logic [DATA_W-1:0] retire_operand,
	input wire logic retire_branch_taken,
	output logic redirect_valid,
	output logic [ADDR_W-1:0] redirect_addr,
	output logic [COUNT_W-1:0] iteration_count,
	output logic [INFO_W-1:0] iteration_info_field,
	output logic extended_mode,
	output logic dsp_flag,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	function automatic logic [INFO_W-1:0] info_of(input logic [COUNT_W-1:0] cnt);
		// Saturated small count: 0, 1, 2, or 3 for three and above
		if (cnt >= 12'h003) begin
			return 2'h3;
		end
		return cnt[INFO_W-1:0];
	endfunction : info_of

	function automatic logic reg_mapped(input logic [AXI_ADDR_W-1:0] a);
		return (a == OFS_START) || (a == OFS_END) || (a == OFS_STATE) || (a == OFS_STATUS);
	endfunction : reg_mapped

	// Loop state
	logic [ADDR_W-1:0] start_reg, start_next;
	logic [ADDR_W-1:0] end_reg, end_next;
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [INFO_W-1:0] info_reg, info_next;
	logic dsp_reg, dsp_next;
	logic redir_reg, redir_next;
	logic [ADDR_W-1:0] redir_addr_reg, redir_addr_next;
	logic match_reg, match_next;

	// Write channel state
	zol_wr_state_t wr_state_reg, wr_state_next;
	logic aw_got_reg, aw_got_next;
	logic w_got_reg, w_got_next;
	logic [AXI_ADDR_W-1:0] waddr_reg, waddr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic [1:0] bresp_reg, bresp_next;

	// Read channel state
	zol_rd_state_t rd_state_reg, rd_state_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	logic end_hit;
	logic sw_write;
	logic [ADDR_W-1:0] pc_rel;
	logic [ADDR_W-1:0] disp_x2;
	logic [DATA_W-1:0] state_word;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] state_wr;

	zol_end_match u_match (
		.inst_addr(retire_addr),
		.end_ptr(end_reg),
		.count(count_reg),
		.hit(end_hit)
	);

	assign pc_rel = retire_addr + PC_REL_OFFSET;
	assign disp_x2 = {{(ADDR_W-DISP_W-1){retire_disp[DISP_W-1]}}, retire_disp, 1'b0};
	assign sw_write = (wr_state_reg == ZOL_WR_COLLECT) && aw_got_reg && w_got_reg;

	always_comb begin
		state_word = '0;
		state_word[STATE_COUNT_LSB +: COUNT_W] = count_reg;
		state_word[STATE_INFO_LSB +: INFO_W] = info_reg;
		state_word[STATE_DSP_BIT] = dsp_reg;
		status_word = '0;
		status_word[STATUS_EXT_BIT] = end_reg[END_MODE_BIT];
		status_word[STATUS_ARMED_BIT] = (count_reg != COUNT_RESET);
		status_word[STATUS_MATCH_BIT] = match_reg;
	end

	// Loop state next values; pipeline effects override a same-cycle software write
	always_comb begin
		start_next = start_reg;
		end_next = end_reg;
		count_next = count_reg;
		info_next = info_reg;
		dsp_next = dsp_reg;
		redir_next = 1'b0;
		redir_addr_next = redir_addr_reg;
		match_next = match_reg;
		state_wr = state_word;
		if (sw_write && waddr_reg == OFS_START) begin
			start_next = apply_strb(start_reg, wdata_reg, wstrb_reg);
		end else if (sw_write && waddr_reg == OFS_END) begin
			end_next = apply_strb(end_reg, wdata_reg, wstrb_reg);
		end else if (sw_write && waddr_reg == OFS_STATE) begin
			state_wr = apply_strb(state_word, wdata_reg, wstrb_reg);
		end
		if (sw_write && waddr_reg == OFS_STATE) begin
			count_next = state_wr[STATE_COUNT_LSB +: COUNT_W];
			info_next = state_wr[STATE_INFO_LSB +: INFO_W];
			dsp_next = state_wr[STATE_DSP_BIT];
		end
		if (retire_valid) begin
			match_next = end_hit;
			if (end_hit) begin
				// Recognised as the loop end retires, whatever path led here
				count_next = count_reg - 12'h001;
				info_next = info_of(count_reg - 12'h001);
				if (count_reg >= 12'h002 && !retire_branch_taken) begin
					redir_next = 1'b1;
					redir_addr_next = start_reg;
				end
			end
			case (retire_op)
				OP_SET_START: begin
					start_next = disp_x2 + pc_rel;
				end
				OP_SET_END: begin
					// Keep the mode marker while the pointer moves
					end_next = {disp_x2[ADDR_W-1:1] + pc_rel[ADDR_W-1:1], end_reg[END_MODE_BIT]};
				end
				OP_COUNT_IMM: begin
					count_next = {{(COUNT_W-IMM_W){1'b0}}, retire_operand[IMM_W-1:0]};
					info_next = info_of({{(COUNT_W-IMM_W){1'b0}}, retire_operand[IMM_W-1:0]});
					end_next[END_MODE_BIT] = 1'b1;
				end
				OP_COUNT_REG: begin
					count_next = retire_operand[COUNT_W-1:0];
					info_next = info_of(retire_operand[COUNT_W-1:0]);
					end_next[END_MODE_BIT] = 1'b1;
				end
				OP_LEGACY_SETUP: begin
					count_next = retire_operand[COUNT_W-1:0];
					info_next = info_of(retire_operand[COUNT_W-1:0]);
					end_next[END_MODE_BIT] = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_reg <= START_RESET;
			end_reg <= END_RESET;
			count_reg <= COUNT_RESET;
			info_reg <= INFO_RESET;
			dsp_reg <= 1'b0;
			redir_reg <= 1'b0;
			redir_addr_reg <= START_RESET;
			match_reg <= 1'b0;
		end else if (ce) begin
			start_reg <= start_next;
			end_reg <= end_next;
			count_reg <= count_next;
			info_reg <= info_next;
			dsp_reg <= dsp_next;
			redir_reg <= redir_next;
			redir_addr_reg <= redir_addr_next;
			match_reg <= match_next;
		end
	end

	// Write channel: address and data taken in either order
	always_comb begin
		wr_state_next = wr_state_reg;
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bresp_next = bresp_reg;
		case (wr_state_reg)
			ZOL_WR_COLLECT: begin
				if (s_axi_awvalid && !aw_got_reg) begin
					aw_got_next = 1'b1;
					waddr_next = {s_axi_awaddr[AXI_ADDR_W-1:2], 2'b00};
				end
				if (s_axi_wvalid && !w_got_reg) begin
					w_got_next = 1'b1;
					wdata_next = s_axi_wdata;
					wstrb_next = s_axi_wstrb;
				end
				if (sw_write) begin
					aw_got_next = 1'b0;
					w_got_next = 1'b0;
					bresp_next = (reg_mapped(waddr_reg) && waddr_reg != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
					wr_state_next = ZOL_WR_RESP;
				end
			end
			ZOL_WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_next = ZOL_WR_COLLECT;
				end
			end
			default: begin
				wr_state_next = ZOL_WR_COLLECT;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= ZOL_WR_COLLECT;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bresp_reg <= RESP_OKAY;
		end else if (ce) begin
			wr_state_reg <= wr_state_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bresp_reg <= bresp_next;
		end
	end

	// Read channel
	always_comb begin
		rd_state_next = rd_state_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rd_state_reg)
			ZOL_RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_state_next = ZOL_RD_DATA;
					rresp_next = RESP_OKAY;
					if (s_axi_araddr[AXI_ADDR_W-1:2] == OFS_START[AXI_ADDR_W-1:2]) begin
						rdata_next = start_reg;
					end else if (s_axi_araddr[AXI_ADDR_W-1:2] == OFS_END[AXI_ADDR_W-1:2]) begin
						rdata_next = end_reg;
					end else if (s_axi_araddr[AXI_ADDR_W-1:2] == OFS_STATE[AXI_ADDR_W-1:2]) begin
						rdata_next = state_word;
					end else if (s_axi_araddr[AXI_ADDR_W-1:2] == OFS_STATUS[AXI_ADDR_W-1:2]) begin
						rdata_next = status_word;
					end else begin
						rdata_next = '0;
						rresp_next = RESP_SLVERR;
					end
				end
			end
			ZOL_RD_DATA: begin
				if (s_axi_rready) begin
					rd_state_next = ZOL_RD_IDLE;
				end
			end
			default: begin
				rd_state_next = ZOL_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= ZOL_RD_IDLE;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (ce) begin
			rd_state_reg <= rd_state_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = ce && (wr_state_reg == ZOL_WR_COLLECT) && !aw_got_reg;
	assign s_axi_wready = ce && (wr_state_reg == ZOL_WR_COLLECT) && !w_got_reg;
	assign s_axi_bvalid = (wr_state_reg == ZOL_WR_RESP);
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ce && (rd_state_reg == ZOL_RD_IDLE);
	assign s_axi_rvalid = (rd_state_reg == ZOL_RD_DATA);
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	assign redirect_valid = redir_reg;
	assign redirect_addr = redir_addr_reg;
	assign iteration_count = count_reg;
	assign iteration_info_field = info_reg;
	assign extended_mode = end_reg[END_MODE_BIT];
	assign dsp_flag = dsp_reg;

endmodule : zol_loop_ctrl

`default_nettype wire

// File: verification/zol_loop_ctrl_monitor.sv
/* Port checker for the loop controller.
   Bound to zol_loop_ctrl; one clock domain, sees top ports only. */
`timescale 1ns/1ps
`default_nettype none
module zol_loop_ctrl_monitor
	import zol_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic retire_valid,
	input wire logic [OP_W-1:0] retire_op,
	input wire logic [DATA_W-1:0] retire_operand,
	input wire logic retire_branch_taken,
	input wire logic redirect_valid,
	input wire logic [COUNT_W-1:0] iteration_count,
	input wire logic [INFO_W-1:0] iteration_info_field,
	input wire logic extended_mode
);
	wire logic rt = retire_valid && ce;
	wire logic ld = rt && retire_op inside {OP_COUNT_IMM, OP_COUNT_REG, OP_LEGACY_SETUP};
	wire logic go = rt && iteration_count >= 12'h002 && !retire_branch_taken;
	wire logic [7:0] imm = retire_operand[7:0];
	wire logic [11:0] reg_cnt = retire_operand[11:0];
	wire logic [1:0] inf = iteration_count > 12'h003 ? 2'h3 : iteration_count[1:0];
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_redir_cause: assert property (redirect_valid |-> $past(go))
		else $error("redirect without a qualifying loop end");
	a_redir_dec: assert property (redirect_valid && !$past(ld) |-> iteration_count == $past(iteration_count) - 12'h001)
		else $error("redirect without matching count decrement");
	a_imm_load: assert property (rt && retire_op == OP_COUNT_IMM |=>
		iteration_count == {4'h0, $past(imm)} && extended_mode && iteration_info_field == inf)
		else $error("immediate count load wrong");
	a_reg_load: assert property (rt && retire_op == OP_COUNT_REG |=> iteration_count == $past(reg_cnt) && extended_mode)
		else $error("register count load wrong");
	a_legacy_mode: assert property (rt && retire_op == OP_LEGACY_SETUP |=> !extended_mode)
		else $error("legacy setup left extended mode on");
	a_zero_idle: assert property (rt && iteration_count == 12'h000 && !ld |=> !redirect_valid && iteration_count == 12'h000)
		else $error("zero count loop acted");
	a_last_pass: assert property (rt && iteration_count == 12'h001 && !ld |=> !redirect_valid)
		else $error("redirect on last pass");
	a_taken_branch: assert property (rt && retire_branch_taken |=> !redirect_valid)
		else $error("redirect over a taken branch");
	cover property (redirect_valid);
	cover property (rt && retire_op == OP_COUNT_REG);
	cover property (rt && iteration_count == 12'h001);
endmodule : zol_loop_ctrl_monitor

bind zol_loop_ctrl zol_loop_ctrl_monitor i_mon (.aclk, .aresetn, .ce, .retire_valid, .retire_op, .retire_operand,
	.retire_branch_taken, .redirect_valid, .iteration_count, .iteration_info_field, .extended_mode);
`default_nettype wire

// File: verification/zol_pipe_model.sv
/* Retire stage of the surrounding pipeline.
   Presents one retiring instruction per issue pulse; all fields but retire_disp toggle when idle. */
`timescale 1ns/1ps
`default_nettype none
module zol_pipe_model
	import zol_pkg::*;
(
	input wire logic aclk,
	input wire logic issue,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [OP_W-1:0] op_in,
	input wire logic [7:0] disp_in,
	input wire logic [DATA_W-1:0] opnd_in,
	input wire logic br_in,
	output logic retire_valid,
	output logic [ADDR_W-1:0] retire_addr,
	output logic [OP_W-1:0] retire_op,
	output logic [7:0] retire_disp,
	output logic [DATA_W-1:0] retire_operand,
	output logic retire_branch_taken
);
	initial begin
		{retire_valid, retire_addr, retire_op, retire_disp, retire_operand, retire_branch_taken} = '0;
	end
	always @(posedge aclk) begin
		retire_valid <= issue;
		if (issue) begin
			retire_addr <= addr_in;
			retire_op <= op_in;
			retire_disp <= disp_in;
			retire_operand <= opnd_in;
			retire_branch_taken <= br_in;
		end else begin
			// Stale fields must never look like a real instruction
			retire_addr <= ~retire_addr;
			retire_op <= ~retire_op;
			retire_operand <= ~retire_operand;
			retire_branch_taken <= ~retire_branch_taken;
		end
	end
endmodule : zol_pipe_model
`default_nettype wire

// File: verification/tb_zol_loop_ctrl.sv
/* Self-checking bench for the loop controller.
   Assumes zol_pkg, the pipeline model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_zol_loop_ctrl
	import zol_pkg::*;
;
	typedef struct packed {logic rv; logic [31:0] ra; logic [11:0] c; logic x;} zol_exp_t;
	logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, issue = 1'h0, br_in = 1'h0;
	logic [31:0] addr_in = '0, opnd_in = '0, s_axi_wdata = '0, s_axi_rdata, redirect_addr, m_start = '0, m_end = '0, a, v;
	logic [2:0] op_in = '0, retire_op, op;
	logic [7:0] disp_in = '0, retire_disp, s_axi_awaddr = '0, s_axi_araddr = '0, d;
	logic [31:0] retire_addr, retire_operand;
	logic retire_valid, retire_branch_taken, redirect_valid, extended_mode, dsp_flag;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, iteration_info_field;
	logic [11:0] iteration_count, m_cnt = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	zol_exp_t eq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	zol_loop_ctrl i_dut (.aclk, .aresetn, .ce, .retire_valid, .retire_addr, .retire_op, .retire_disp, .retire_operand,
		.retire_branch_taken, .redirect_valid, .redirect_addr, .iteration_count, .iteration_info_field, .extended_mode,
		.dsp_flag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	zol_pipe_model i_pipe (.aclk, .issue, .addr_in, .op_in, .disp_in, .opnd_in, .br_in, .retire_valid, .retire_addr,
		.retire_op, .retire_disp, .retire_operand, .retire_branch_taken);
	initial begin
		forever #10 aclk = ~aclk;
	end
	function automatic logic [1:0] inf(input logic [11:0] c);
		return c > 12'h003 ? 2'h3 : c[1:0];
	endfunction : inf
	task automatic wrap_up;
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// Retire one instruction and note what the controller must show
	task automatic ret(input logic [31:0] ra, input logic [2:0] o, input logic [7:0] dd, input logic [31:0] vv, input logic b);
		logic hit;
		zol_exp_t e;
		hit = m_cnt != 12'h000 && (m_end[0] ? ra[31:1] == m_end[31:1] : ra == m_end);
		e = {1'h0, m_start, 12'h000, 1'h0};
		e.rv = hit && m_cnt >= 12'h002 && !b;
		if (hit) m_cnt = m_cnt - 12'h001;
		if (o == OP_SET_START) m_start = ra + PC_REL_OFFSET + {{23{dd[7]}}, dd, 1'h0};
		if (o == OP_SET_END) m_end = {ra[31:1] + 31'h2 + {{23{dd[7]}}, dd}, m_end[0]};
		if (o == OP_COUNT_IMM) m_cnt = {4'h0, vv[7:0]};
		if (o == OP_COUNT_REG || o == OP_LEGACY_SETUP) m_cnt = vv[11:0];
		if (o >= OP_COUNT_IMM && o <= OP_LEGACY_SETUP) m_end[0] = o != OP_LEGACY_SETUP;
		e.c = m_cnt;
		e.x = m_end[0];
		eq.push_back(e);
		{issue, addr_in, op_in, disp_in, opnd_in, br_in} <= {1'h1, ra, o, dd, vv, b};
		@(posedge aclk);
		issue <= 1'h0;
		repeat ($urandom_range(3, 1)) @(posedge aclk);
	endtask : ret
	task automatic axw(input logic [7:0] ad, input logic [31:0] dd, input logic [1:0] r);
		logic aw, w, bv;
		bq.push_back(r);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, dd, 3'h7};
		do begin
			@(negedge aclk);
			{aw, w, bv} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
		end while (!bv);
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : axw
	task automatic axr(input logic [7:0] ad, input logic [31:0] dd, input logic [1:0] r);
		logic ar, rv;
		rq.push_back({r, dd});
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
		do begin
			@(negedge aclk);
			{ar, rv} = {s_axi_arready, s_axi_rvalid};
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'h0;
		end while (!rv);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : axr
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			wrap_up();
		end
		if (s_axi_bvalid === 1'h1 && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front())
		if (s_axi_rvalid === 1'h1 && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
		if (retire_valid === 1'h1) begin : pipe_chk
			zol_exp_t e;
			#1;
			e = eq.pop_front();
			`CHK({redirect_valid, iteration_count, extended_mode}, {e.rv, e.c, e.x})
			`CHK(iteration_info_field, inf(e.c))
			if (e.rv) `CHK(redirect_addr, e.ra)
		end
	end
	initial begin
		void'($urandom(64750));
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 4; i++) axr(8'(i * 4), 32'h0, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			a = $urandom & 32'h00ff_fffe;
			d = 8'($urandom);
			ret(a, OP_SET_START, d, 32'h0, 1'h0);
			ret(a + (i == 3 ? 32'h0 : 32'h10), OP_SET_END, d, 32'h0, 1'h0);
			axr(OFS_START, m_start, RESP_OKAY);
			axr(OFS_END, m_end, RESP_OKAY);
			op = i == 5 ? OP_LEGACY_SETUP : (i == 4 ? OP_COUNT_REG : OP_COUNT_IMM);
			v = i < 3 ? i : (i == 5 ? 32'h3 : $urandom);
			ret(a + 32'h20, op, 8'h0, v, 1'h0);
			ret(a + 32'h22, OP_NONE, 8'h0, 32'h0, 1'h0);
			axr(OFS_STATE, {18'h0, inf(m_cnt), m_cnt}, RESP_OKAY);
			repeat (m_cnt + 1) begin
				ret(m_start, OP_NONE, 8'h0, 32'h0, 1'h0);
				ret({m_end[31:1], 1'($urandom)}, OP_NONE, 8'h0, 32'h0, $urandom_range(5, 0) == 0);
			end
		end
		axr(8'h10, 32'h0, RESP_SLVERR);
		axw(OFS_STATUS, $urandom, RESP_SLVERR);
		axw(8'h20, $urandom, RESP_SLVERR);
		m_cnt = 12'h005;
		axw(OFS_STATE, {18'h0, 2'h3, m_cnt}, RESP_OKAY);
		axw(OFS_END, m_end, RESP_OKAY);
		repeat (6) ret(m_end, OP_NONE, 8'h0, 32'h0, 1'h0);
		repeat (4) @(posedge aclk);
		wrap_up();
	end
endmodule : tb_zol_loop_ctrl
`default_nettype wire
